// ### verilog/pso_pkg.sv
// package: constants, register map and ui states of the pressure switch
`default_nettype none
package pso_pkg;
    // ========================================================================
    // timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int MS_NS = 1000000;
    localparam int TICK_CYCLES = MS_NS / CLK_PERIOD_NS; // cycles per 1 ms
    localparam int LONG_PRESS_MS = 200;
    localparam int ABORT_MS = 2000;
    localparam int DEBOUNCE_MS = 20;
    localparam logic [15:0] DELAY_MAX_MS = 16'hC350; // 50 s
    // ========================================================================
    // register map, byte addresses
    localparam logic [7:0] OFS_LVL1A = 8'h00; // on level or window high, 1
    localparam logic [7:0] OFS_LVL1B = 8'h04; // back level or window low, 1
    localparam logic [7:0] OFS_LVL2A = 8'h08;
    localparam logic [7:0] OFS_LVL2B = 8'h0C;
    localparam logic [7:0] OFS_DLY1 = 8'h10; // delay in ms
    localparam logic [7:0] OFS_DLY2 = 8'h14;
    localparam logic [7:0] OFS_CTRL = 8'h18;
    localparam logic [7:0] OFS_PWD = 8'h1C;
    localparam logic [7:0] OFS_STAT = 8'h20; // read only
    localparam logic [7:0] OFS_MINMAX = 8'h24; // read, write clears
    localparam int NUM_PARAM = 8;
    localparam logic [2:0] IDX_DLY1 = 3'h4;
    localparam logic [2:0] IDX_CTRL = 3'h6;
    localparam logic [2:0] IDX_PWD = 3'h7;
    // ========================================================================
    // control fields: per output a nibble at 4*n
    localparam int CTRL_WIN = 0; // window mode
    localparam int CTRL_NC = 1; // normally closed polarity
    localparam int CTRL_UNDER = 2; // underpressure hysteresis
    localparam int CTRL_LEAK = 8; // leak test function present
    localparam int CTRL_ANA_LSB = 12; // analog output setting field
    localparam logic [15:0] PARAM_RST = 16'h0000;
    // ========================================================================
    // user interface states
    typedef enum logic [2:0] {
        UI_DISP = 3'h0,
        UI_PWD = 3'h1,
        UI_MENU = 3'h3,
        UI_EDIT = 3'h2,
        UI_INFO = 3'h6,
        UI_LEAK_RUN = 3'h7,
        UI_LEAK_DONE = 3'h5
    } pso_ui_t;
    localparam logic [2:0] INFO_LAST = 3'h6;
    localparam int BTN_UP = 0;
    localparam int BTN_ENT = 1;
    localparam int BTN_DN = 2;
endpackage : pso_pkg
`default_nettype wire

// ### verilog/pso_btn_if.sv
// interface: classified pushbutton events between front end and ui logic
`default_nettype none
interface pso_btn_if;
    logic tick; // 1 ms strobe
    logic [2:0] level; // debounced held level
    logic [2:0] brief; // pulse on release of a short press
    logic [2:0] long_p; // pulse when hold reaches long threshold
    logic [2:0] abort; // pulse when hold reaches abort threshold
    modport drv (input tick, output level, brief, long_p, abort);
    modport sink (output tick, input level, brief, long_p, abort);
endinterface : pso_btn_if
`default_nettype wire

// ### verilog/pso_buttons.sv
// module: debounce and press-length classification of three pushbuttons
`default_nettype none
module pso_buttons
    import pso_pkg::*;
#(
    parameter int HOLD_W = 11,
    parameter int DB_W = 5
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [2:0] i_btn,
    pso_btn_if.drv btn
);
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_btn
            logic stable_r;
            logic [DB_W-1:0] db_r;
            logic [HOLD_W-1:0] hold_r;
            // debounce: raw level must differ for DEBOUNCE_MS ticks
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    stable_r <= 1'b0;
                    db_r <= '0;
                end else if (i_btn[g] == stable_r) begin
                    db_r <= '0;
                end else if (btn.tick) begin
                    if (db_r == DB_W'(DEBOUNCE_MS - 1)) begin
                        stable_r <= i_btn[g];
                        db_r <= '0;
                    end else begin
                        db_r <= db_r + 1'b1;
                    end
                end
            end
            // hold time in ms, saturating at the abort threshold
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    hold_r <= '0;
                end else if (!stable_r) begin
                    hold_r <= '0;
                end else if (btn.tick && hold_r != HOLD_W'(ABORT_MS)) begin
                    hold_r <= hold_r + 1'b1;
                end
            end
            // press classes; brief fires on release only
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    btn.brief[g] <= 1'b0;
                    btn.long_p[g] <= 1'b0;
                    btn.abort[g] <= 1'b0;
                end else begin
                    btn.brief[g] <= stable_r && db_r == DB_W'(DEBOUNCE_MS - 1)
                        && btn.tick && !i_btn[g]
                        && hold_r < HOLD_W'(LONG_PRESS_MS);
                    btn.long_p[g] <= stable_r && btn.tick
                        && hold_r == HOLD_W'(LONG_PRESS_MS);
                    btn.abort[g] <= stable_r && btn.tick
                        && hold_r == HOLD_W'(ABORT_MS - 1);
                end
            end
            assign btn.level[g] = stable_r;
        end
    endgenerate
endmodule : pso_buttons
`default_nettype wire

// ### verilog/pso_top.sv
// module: pressure switch comparators, user interface and ahb-lite registers
`default_nettype none
module pso_top
    import pso_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYCLES,
    parameter int PW = 16
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    // ahb-lite slave
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [31:0] o_hrdata,
    // process side
    input wire logic [PW-1:0] i_pressure,
    input wire logic [2:0] i_btn,
    input wire logic i_leak_done,
    output logic [1:0] o_switch,
    output logic [2:0] o_ui_mode,
    output logic [2:0] o_cursor,
    output logic [15:0] o_edit_value,
    output logic [15:0] o_show_value,
    output logic o_leak_run
);
    // ========================================================================
    // decoding shared by read and write paths
    function automatic logic [3:0] reg_index(input logic [7:0] a);
        reg_index = {1'b0, a[4:2]};
        if (a == OFS_STAT) begin
            reg_index = 4'h8;
        end else if (a == OFS_MINMAX) begin
            reg_index = 4'h9;
        end else if (a > OFS_MINMAX || a[1:0] != 2'h0) begin
            reg_index = 4'hF;
        end
    endfunction : reg_index

    function automatic logic [15:0] clamp_param(input logic [2:0] idx,
                                                input logic [15:0] v);
        clamp_param = v;
        if ((idx == IDX_DLY1 || idx == IDX_DLY1 + 3'h1)
                && v > DELAY_MAX_MS) begin
            clamp_param = DELAY_MAX_MS;
        end
    endfunction : clamp_param

    // ========================================================================
    // millisecond tick
    logic [16:0] pre_r;
    pso_btn_if btn ();

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pre_r <= '0;
        end else if (pre_r == 17'(TICK_CYC - 1)) begin
            pre_r <= '0;
        end else begin
            pre_r <= pre_r + 1'b1;
        end
    end
    assign btn.tick = (pre_r == 17'(TICK_CYC - 1));

    pso_buttons u_buttons (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_btn(i_btn),
        .btn(btn)
    );

    // ========================================================================
    // committed parameters; the comparators only ever see these
    logic [15:0] param_r [NUM_PARAM];
    logic [15:0] edit_r;
    logic [2:0] cursor_r;
    logic [2:0] info_r;
    pso_ui_t ui_r;
    logic leak_arm_r;
    logic [PW-1:0] low_r;
    logic [PW-1:0] high_r;
    logic [1:0] sw_r;
    logic bus_wr_r;
    logic [3:0] bus_idx_r;
    logic mm_clr;
    logic commit;
    logic combo;
    logic [15:0] ctrl;

    assign ctrl = param_r[IDX_CTRL];
    assign commit = (ui_r == UI_EDIT) && btn.brief[BTN_ENT];
    assign mm_clr = bus_wr_r && bus_idx_r == 4'h9;
    assign combo = btn.level[BTN_UP] && btn.level[BTN_DN];

    // parameter store: a bus write wins over a menu commit in the same cycle
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < NUM_PARAM; i++) begin
                param_r[i] <= PARAM_RST;
            end
        end else if (bus_wr_r && !bus_idx_r[3]) begin
            param_r[bus_idx_r[2:0]] <= clamp_param(bus_idx_r[2:0],
                                                   i_hwdata[15:0]);
        end else if (commit) begin
            param_r[cursor_r] <= clamp_param(cursor_r, edit_r);
        end
    end

    // ========================================================================
    // two switching channels
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_out
            logic [15:0] dly_r;
            logic want;
            logic [PW-1:0] lvl_a;
            logic [PW-1:0] lvl_b;
            logic win;
            logic nc;
            logic under;
            assign lvl_a = PW'(param_r[2*g]);
            assign lvl_b = PW'(param_r[2*g+1]);
            assign win = ctrl[4*g+CTRL_WIN];
            assign nc = ctrl[4*g+CTRL_NC];
            assign under = ctrl[4*g+CTRL_UNDER];

            // target state before the delay filter
            always_comb begin
                want = sw_r[g];
                if (win) begin
                    want = (i_pressure >= lvl_b) && (i_pressure <= lvl_a);
                end else if (under) begin
                    if (i_pressure <= lvl_a) begin
                        want = 1'b1;
                    end else if (i_pressure >= lvl_b) begin
                        want = 1'b0;
                    end
                end else begin
                    if (i_pressure >= lvl_a) begin
                        want = 1'b1;
                    end else if (i_pressure <= lvl_b) begin
                        want = 1'b0;
                    end
                end
            end

            // delay: condition must hold for the set number of ms
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    sw_r[g] <= 1'b0;
                    dly_r <= '0;
                end else if (want == sw_r[g]) begin
                    dly_r <= '0; // condition gone, restart timing
                end else if (dly_r > param_r[IDX_DLY1 + 3'(g)]
                        || param_r[IDX_DLY1 + 3'(g)] == 16'h0000) begin
                    // one spare tick: the first tick may come at once
                    sw_r[g] <= want;
                    dly_r <= '0;
                end else if (btn.tick) begin
                    dly_r <= dly_r + 1'b1;
                end
            end

            // polarity applied last so both modes share the hysteresis
            always_ff @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    o_switch[g] <= 1'b0;
                end else begin
                    o_switch[g] <= sw_r[g] ^ nc;
                end
            end
        end
    endgenerate

    // ========================================================================
    // low and high pressure seen since reset or last clear
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            low_r <= '1;
            high_r <= '0;
        end else if (mm_clr) begin
            low_r <= i_pressure;
            high_r <= i_pressure;
        end else begin
            if (i_pressure < low_r) begin
                low_r <= i_pressure;
            end
            if (i_pressure > high_r) begin
                high_r <= i_pressure;
            end
        end
    end

    // ========================================================================
    // user interface state machine
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ui_r <= UI_DISP;
        end else begin
            unique case (ui_r)
                UI_DISP: begin
                    // brief presses fall through here with no effect
                    if (combo) begin
                        ui_r <= UI_DISP;
                    end else if (btn.long_p[BTN_UP]) begin
                        ui_r <= UI_INFO;
                    end else if (btn.long_p[BTN_DN]) begin
                        ui_r <= (param_r[IDX_PWD] != 16'h0000) ? UI_PWD
                                                               : UI_MENU;
                    end else if (btn.long_p[BTN_ENT] && ctrl[CTRL_LEAK]) begin
                        ui_r <= UI_LEAK_RUN;
                    end
                end
                UI_INFO: begin
                    if (btn.long_p[BTN_UP] && info_r == INFO_LAST) begin
                        ui_r <= UI_DISP;
                    end
                end
                UI_PWD: begin
                    if (combo) begin
                        ui_r <= UI_DISP;
                    end else if (btn.brief[BTN_ENT]) begin
                        ui_r <= (edit_r == param_r[IDX_PWD]) ? UI_MENU
                                                             : UI_DISP;
                    end
                end
                UI_MENU: begin
                    if (combo) begin
                        ui_r <= UI_DISP;
                    end else if (btn.brief[BTN_ENT]) begin
                        ui_r <= UI_EDIT;
                    end
                end
                UI_EDIT: begin
                    if (combo) begin
                        ui_r <= UI_DISP;
                    end else if (btn.brief[BTN_ENT]) begin
                        ui_r <= UI_MENU;
                    end
                end
                UI_LEAK_RUN: begin
                    if (btn.abort[BTN_ENT] && leak_arm_r) begin
                        ui_r <= UI_DISP;
                    end else if (i_leak_done) begin
                        ui_r <= UI_LEAK_DONE;
                    end
                end
                UI_LEAK_DONE: begin
                    if (btn.long_p[BTN_ENT]) begin
                        ui_r <= UI_DISP;
                    end
                end
                default: begin
                    ui_r <= UI_DISP;
                end
            endcase
        end
    end

    // the start press must be released before a hold can cancel the run
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            leak_arm_r <= 1'b0;
        end else if (ui_r != UI_LEAK_RUN) begin
            leak_arm_r <= 1'b0;
        end else if (!btn.level[BTN_ENT]) begin
            leak_arm_r <= 1'b1;
        end
    end

    // info page index
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            info_r <= '0;
        end else if (ui_r != UI_INFO) begin
            info_r <= '0;
        end else if (btn.long_p[BTN_UP]) begin
            info_r <= (info_r == INFO_LAST) ? 3'h0 : info_r + 3'h1;
        end
    end

    // menu cursor, moves only while browsing
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cursor_r <= '0;
        end else if (ui_r == UI_DISP) begin
            cursor_r <= '0;
        end else if (ui_r == UI_MENU && !combo) begin
            if (btn.brief[BTN_UP] || btn.long_p[BTN_UP]) begin
                cursor_r <= cursor_r - 3'h1;
            end else if (btn.brief[BTN_DN] || btn.long_p[BTN_DN]) begin
                cursor_r <= cursor_r + 3'h1;
            end
        end
    end

    // edit value: password entry or working copy of one parameter
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            edit_r <= '0;
        end else if (ui_r == UI_DISP) begin
            edit_r <= '0;
        end else if (ui_r == UI_MENU) begin
            edit_r <= param_r[cursor_r];
        end else if ((ui_r == UI_EDIT || ui_r == UI_PWD) && !combo) begin
            if (btn.brief[BTN_UP] || btn.long_p[BTN_UP]) begin
                edit_r <= edit_r + 16'h0001;
            end else if (btn.brief[BTN_DN] || btn.long_p[BTN_DN]) begin
                edit_r <= edit_r - 16'h0001;
            end
        end
    end

    // value presented to the display
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_show_value <= '0;
        end else if (ui_r == UI_INFO) begin
            if (info_r < 3'h4) begin
                o_show_value <= param_r[info_r];
            end else if (info_r == 3'h4) begin
                o_show_value <= {12'h000, ctrl[CTRL_ANA_LSB +: 4]};
            end else if (info_r == 3'h5) begin
                o_show_value <= 16'(low_r);
            end else begin
                o_show_value <= 16'(high_r);
            end
        end else begin
            o_show_value <= 16'(i_pressure);
        end
    end

    // ========================================================================
    // ahb-lite slave: zero wait states, always OKAY
    logic [31:0] rd_nxt;
    logic [3:0] addr_idx;
    assign addr_idx = reg_index(i_haddr[7:0]);

    always_comb begin
        rd_nxt = 32'h0000_0000;
        if (!addr_idx[3]) begin
            rd_nxt = {16'h0000, param_r[addr_idx[2:0]]};
        end else if (addr_idx == 4'h8) begin
            rd_nxt = {16'h0000, 1'b0, cursor_r, 1'b0, info_r,
                      1'b0, ui_r, 2'b00, sw_r};
        end else if (addr_idx == 4'h9) begin
            rd_nxt = {16'(high_r), 16'(low_r)};
        end
    end

    // address phase capture; read data is prepared for the data phase
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bus_wr_r <= 1'b0;
            bus_idx_r <= 4'hF;
            o_hrdata <= '0;
        end else begin
            bus_wr_r <= i_hsel && i_hready && i_htrans[1] && i_hwrite;
            bus_idx_r <= addr_idx;
            if (i_hsel && i_hready && i_htrans[1] && !i_hwrite) begin
                o_hrdata <= rd_nxt;
            end
        end
    end
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;

    assign o_ui_mode = ui_r;
    assign o_cursor = cursor_r;
    assign o_edit_value = edit_r;
    assign o_leak_run = (ui_r == UI_LEAK_RUN);
endmodule : pso_top
`default_nettype wire

// ### verilog/pso_unused.sv
// file intentionally holds no design unit
`default_nettype none
`default_nettype wire

// ### sim/pso_top_props.sv
// checker: user interface state properties of pso_top
`default_nettype none
module pso_top_props
    import pso_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [2:0] i_btn,
    input wire logic i_leak_done,
    input wire logic [2:0] o_ui_mode,
    input wire logic [2:0] o_cursor,
    input wire logic [15:0] o_edit_value,
    input wire logic o_leak_run
);
    timeunit 1ns;
    timeprecision 1ps;
    // ========================================================
    // state moves, single clock domain
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    sequence left_s(logic [2:0] m);
        $past(o_ui_mode) == m && o_ui_mode != m;
    endsequence
    leak_flag_a: assert property (o_leak_run == (o_ui_mode == 3'h7))
        else $error("leak flag differs from ui state");
    leak_end_a: assert property (
        o_ui_mode == UI_LEAK_RUN && i_leak_done |=> o_ui_mode != UI_LEAK_RUN)
        else $error("leak run did not end");
    leak_quit_a: assert property (
        left_s(UI_LEAK_RUN) |-> $past(i_leak_done) || $past(i_btn[BTN_ENT]))
        else $error("leak run left without cause");
    pwd_exit_a: assert property (
        left_s(UI_PWD) |-> o_ui_mode inside {UI_DISP, UI_MENU})
        else $error("password prompt left to a wrong state");
    edit_exit_a: assert property (
        left_s(UI_EDIT) |-> o_ui_mode inside {UI_MENU, UI_DISP})
        else $error("edit left to a wrong state");
    disp_leave_a: assert property (
        left_s(UI_DISP) |-> $past(i_btn) != 3'h0)
        else $error("display left with no button held");
    cursor_step_a: assert property (
        $past(o_ui_mode) == UI_MENU && o_ui_mode == UI_MENU
        && $changed(o_cursor)
        |-> o_cursor == $past(o_cursor) + 3'h1
        || o_cursor == $past(o_cursor) - 3'h1)
        else $error("cursor moved by more than one");
    edit_step_a: assert property (
        $past(o_ui_mode) == UI_EDIT && o_ui_mode == UI_EDIT
        && $changed(o_edit_value)
        |-> o_edit_value == $past(o_edit_value) + 16'h1
        || o_edit_value == $past(o_edit_value) - 16'h1)
        else $error("edit value moved by more than one");
endmodule : pso_top_props
`default_nettype wire

// ### sim/pso_plc_model.sv
// partner: controller input sampling both switching outputs
`default_nettype none
module pso_plc_model (
    input wire logic i_clk,
    input wire logic [1:0] i_sw,
    output logic [1:0] o_seen
);
    timeunit 1ns;
    timeprecision 1ps;
    // input register, as a controller reads the line once a clock
    always_ff @(posedge i_clk) begin
        o_seen <= i_sw;
    end
endmodule : pso_plc_model
`default_nettype wire

// ### sim/pso_top_test.sv
// testbench: bus, switching and pushbutton scenarios of pso_top
`default_nettype none
module pso_top_test
    import pso_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TK = 10; // short ms tick keeps the run small
    logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, leak = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rdata;
    logic [1:0] htrans = 2'h0, sw, seen;
    logic [15:0] pres = 16'h0, ev, shv;
    logic [2:0] btn = 3'h0, ui, cur;
    logic rdy, resp, lrun;
    int n_errors = 0, samples_checked = 0, cyc = 0;
    pso_top #(.TICK_CYC(TK), .PW(16)) dut_u (.i_clk(clk), .i_rst_n(rst_n),
        .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
        .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(rdy), .o_hreadyout(rdy),
        .o_hresp(resp), .o_hrdata(rdata), .i_pressure(pres), .i_btn(btn),
        .i_leak_done(leak), .o_switch(sw), .o_ui_mode(ui), .o_cursor(cur),
        .o_edit_value(ev), .o_show_value(shv), .o_leak_run(lrun));
    pso_plc_model plc_u (.i_clk(clk), .i_sw(sw), .o_seen(seen));
    // ========================================================
    // clock and hang guard
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 99000) begin
            n_errors++;
            end_sim();
        end
    end
    // ========================================================
    // shared tasks
    task automatic end_sim;
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim
    task automatic check(input string nm, input logic [31:0] s, e);
        samples_checked++;
        if (s !== e) begin
            n_errors++;
            $display("wrong value %s expected %0h seen %0h", nm, e, s);
        end
    endtask : check
    // one single transfer; holds each phase until hready
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (rdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (rdy !== 1'b1);
        q = rdata;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rchk(input string nm, input logic [7:0] a,
        input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(nm, q, e);
        check("response", 32'(resp), 32'h0);
    endtask : rchk
    task automatic press(input logic [2:0] b, input int ms);
        @(posedge clk);
        btn <= b;
        repeat (ms * TK) @(posedge clk);
        btn <= 3'h0;
        repeat (40 * TK) @(posedge clk);
    endtask : press
    task automatic sw_is(input logic [15:0] p, input logic [1:0] e);
        @(posedge clk);
        pres <= p;
        repeat (5) @(posedge clk);
        check("switch", 32'(seen), 32'(e));
    endtask : sw_is
    task automatic ui_is(input logic [2:0] e);
        check("ui mode", 32'(ui), 32'(e));
    endtask : ui_is
    // ========================================================
    // scenarios
    task automatic t_levels;
        wr(OFS_LVL1A, 32'h64);
        wr(OFS_LVL1B, 32'h32);
        wr(OFS_LVL2A, 32'h12C);
        wr(OFS_LVL2B, 32'hFA);
        sw_is(16'h78, 2'h1);
        sw_is(16'h46, 2'h1);
        sw_is(16'h28, 2'h0);
        sw_is(16'h12C, 2'h3);
        wr(OFS_CTRL, 32'h4);
        wr(OFS_LVL1A, 32'h32);
        wr(OFS_LVL1B, 32'h64);
        sw_is(16'h28, 2'h1);
        sw_is(16'h46, 2'h1);
        sw_is(16'h6E, 2'h0);
        wr(OFS_CTRL, 32'h1);
        wr(OFS_LVL1A, 32'h64);
        wr(OFS_LVL1B, 32'h32);
        sw_is(16'h46, 2'h1);
        sw_is(16'h78, 2'h0);
        wr(OFS_CTRL, 32'h3);
        sw_is(16'h46, 2'h0);
        sw_is(16'h1E, 2'h1);
        wr(OFS_MINMAX, 32'h0);
        rchk("low high", OFS_MINMAX, 32'h001E_001E);
    endtask : t_levels
    // a lapse of the condition must restart the delay
    task automatic t_delay;
        wr(OFS_CTRL, 32'h0);
        sw_is(16'h1E, 2'h0);
        wr(OFS_DLY1, 32'h5);
        sw_is(16'h78, 2'h0);
        repeat (25) @(posedge clk);
        pres <= 16'h28;
        @(posedge clk);
        pres <= 16'h78;
        repeat (30) @(posedge clk);
        check("delayed switch", 32'(seen), 32'h0);
        repeat (40) @(posedge clk);
        check("delayed switch", 32'(seen), 32'h1);
        wr(OFS_DLY2, 32'hFFFF);
        rchk("delay clamp", OFS_DLY2, 32'(DELAY_MAX_MS));
    endtask : t_delay
    task automatic t_prog;
        press(3'h2, 60);
        ui_is(UI_DISP);
        press(3'h5, 250);
        ui_is(UI_DISP);
        press(3'h4, 250);
        ui_is(UI_MENU);
        press(3'h4, 60);
        check("cursor", 32'(cur), 32'h1);
        press(3'h1, 60);
        check("cursor", 32'(cur), 32'h0);
        press(3'h2, 60);
        ui_is(UI_EDIT);
        press(3'h1, 60);
        check("edit value", 32'(ev), 32'h65);
        rchk("level kept", OFS_LVL1A, 32'h64);
        press(3'h2, 60);
        rchk("level set", OFS_LVL1A, 32'h65);
        press(3'h5, 250);
        ui_is(UI_DISP);
        wr(OFS_PWD, 32'h5);
        press(3'h4, 250);
        ui_is(UI_PWD);
        press(3'h2, 60);
        ui_is(UI_DISP);
        press(3'h4, 250);
        repeat (5) press(3'h1, 60);
        press(3'h2, 60);
        ui_is(UI_MENU);
        press(3'h5, 250);
    endtask : t_prog
    task automatic t_info_leak;
        press(3'h1, 250);
        check("info page", 32'(shv), 32'h65);
        press(3'h1, 250);
        check("info page", 32'(shv), 32'h32);
        repeat (6) press(3'h1, 250);
        ui_is(UI_DISP);
        wr(OFS_CTRL, 32'h100);
        press(3'h2, 250);
        check("leak run", 32'(lrun), 32'h1);
        leak <= 1'b1;
        @(posedge clk);
        leak <= 1'b0;
        repeat (3) @(posedge clk);
        ui_is(UI_LEAK_DONE);
        press(3'h2, 250);
        ui_is(UI_DISP);
        press(3'h2, 250);
        check("leak run", 32'(lrun), 32'h1);
        press(3'h2, 2100);
        ui_is(UI_DISP);
    endtask : t_info_leak
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_levels();
        t_delay();
        t_prog();
        t_info_leak();
        end_sim();
    end
endmodule : pso_top_test
bind pso_top pso_top_props chk_u (.i_clk, .i_rst_n, .i_btn, .i_leak_done,
    .o_ui_mode, .o_cursor, .o_edit_value, .o_leak_run);
`default_nettype wire
